// ==== src/swl_cfg.svh ====
// Constants of the single-wire register link
`ifndef SWL_CFG_SVH
`define SWL_CFG_SVH
`define SWL_CLK_MHZ       250
`define SWL_CNT_W         20
`define SWL_T_BREAK_US    190
`define SWL_T_RECOVER_US  50
`define SWL_T_START_US    60
`define SWL_T_SAMPLE_US   100
`define SWL_T_STOPSU_US   240
`define SWL_T_BIT_US      3004
`define SWL_CMD_WR_BIT    7
`define SWL_LAST_BIT      3'h7
`define SWL_ADDR_NACH     7'h03
`define SWL_ADDR_BATID    7'h04
`define SWL_ADDR_LMD      7'h05
`define SWL_ADDR_DMF      7'h0A
`define SWL_ADDR_VTS      7'h0C
`define SWL_ADDR_RST      7'h39
`define SWL_RST_BIT       7
`define SWL_ZERO_RST      8'h00
`define SWL_DMF_RST       8'h96
`endif

// ==== src/swl_pkg.sv ====
// Types of the single-wire register link
package swl_pkg;
  typedef enum logic [2:0] {
    SWL_IDLE, SWL_RECOVER, SWL_RX_CMD, SWL_RX_DATA, SWL_TURN, SWL_TX
  } swl_state_type;

  typedef struct packed {
    logic          sync1;
    logic          sync2;
    logic          line_d;
    swl_state_type state;
    logic [19:0]   cnt;
    logic [19:0]   low_cnt;
    logic          in_frame;
    logic [2:0]    bit_idx;
    logic [7:0]    shift;
    logic [7:0]    cmd;
    logic          wr_en;
    logic          dq_oe;
  } swl_port_type;

  typedef struct packed {
    logic [7:0] nac_high;
    logic [7:0] batt_id;
    logic [7:0] last_dis;
    logic [7:0] mag_filter;
    logic [7:0] threshold;
    logic       reset_req;
    logic [7:0] rd_data;
  } swl_regs_type;
endpackage

// ==== src/swl_regfile.sv ====
// Writable gauge registers reached through the serial link
`timescale 1ns/100ps
`default_nettype none
`include "swl_cfg.svh"
module swl_regfile import swl_pkg::*; (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       wr_en_i,
  input  wire logic [6:0] addr_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic [7:0] gauge_data_i,
  output var  logic [7:0] nac_high_o,
  output var  logic [7:0] batt_id_o,
  output var  logic [7:0] last_dis_o,
  output var  logic [7:0] mag_filter_o,
  output var  logic [7:0] threshold_o,
  output var  logic       reset_req_o,
  output var  logic [7:0] rd_data_o
);
  swl_regs_type st;
  swl_regs_type next_st;
  logic         addr_ok;

  always_comb begin
    next_st = st;
    next_st.reset_req = 1'b0;
    addr_ok = 1'b1;
    unique case (addr_i)
      `SWL_ADDR_NACH: next_st.rd_data = st.nac_high;
      `SWL_ADDR_BATID: next_st.rd_data = st.batt_id;
      `SWL_ADDR_LMD: next_st.rd_data = st.last_dis;
      `SWL_ADDR_DMF: next_st.rd_data = st.mag_filter;
      `SWL_ADDR_VTS: next_st.rd_data = st.threshold;
      `SWL_ADDR_RST: next_st.rd_data = `SWL_ZERO_RST;
      default: begin
        // Read-only and unknown indices come from the gauge core
        next_st.rd_data = gauge_data_i;
        addr_ok = 1'b0;
      end
    endcase
    if (wr_en_i && addr_ok) begin // R12
      unique case (addr_i)
        `SWL_ADDR_NACH: next_st.nac_high = wr_data_i;
        `SWL_ADDR_BATID: next_st.batt_id = wr_data_i;
        `SWL_ADDR_LMD: next_st.last_dis = wr_data_i;
        `SWL_ADDR_DMF: next_st.mag_filter = wr_data_i;
        `SWL_ADDR_VTS: next_st.threshold = wr_data_i;
        default: next_st.reset_req = wr_data_i[`SWL_RST_BIT];
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st <= '{nac_high: `SWL_ZERO_RST, batt_id: `SWL_ZERO_RST, last_dis: `SWL_ZERO_RST,
              mag_filter: `SWL_DMF_RST, threshold: `SWL_ZERO_RST, reset_req: 1'b0,
              rd_data: `SWL_ZERO_RST};
    end else begin
      st <= next_st;
    end
  end

  assign nac_high_o   = st.nac_high;
  assign batt_id_o    = st.batt_id;
  assign last_dis_o   = st.last_dis;
  assign mag_filter_o = st.mag_filter;
  assign threshold_o  = st.threshold;
  assign reset_req_o  = st.reset_req;
  assign rd_data_o    = st.rd_data;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_bad_write_kept: assert property ( // R12
    (wr_en_i && !addr_ok) |=> ({st.nac_high, st.batt_id, st.last_dis, st.mag_filter,
      st.threshold} == $past({st.nac_high, st.batt_id, st.last_dis, st.mag_filter,
      st.threshold})) && !st.reset_req)
    else $error("write to unmapped index changed a register");
endmodule // swl_regfile
`default_nettype wire

// ==== src/swl_port.sv ====
// Return-to-one single-wire serial port of the gauge
`timescale 1ns/100ps
`default_nettype none
`include "swl_cfg.svh"
// Behaviour
// [R1] Host pulls line up, or leaves it open
// [R2] Command byte leads; then store or send
// [R3] Eight-bit streams, at most 333 bits/s
// [R4] Bytes travel least significant bit first
// [R5] Long low is line reset, then ready
// [R6] Transmitter opens each frame driving low
// [R7] Bit valid by setup, held through valid
// [R8] Release high by stop setup, stay high
// [R9] Command loads after eight valid bits only
// [R10] Bit seven: zero sends, one writes
// [R11] Register index is command bits six..zero
// [R12] Writes to unmapped indices are discarded
// [R13] After transfer release line, await command
module swl_port import swl_pkg::*; #(
  parameter int BREAK_CYC   = `SWL_T_BREAK_US * `SWL_CLK_MHZ,
  parameter int RECOVER_CYC = `SWL_T_RECOVER_US * `SWL_CLK_MHZ,
  parameter int START_CYC   = `SWL_T_START_US * `SWL_CLK_MHZ,
  parameter int SAMPLE_CYC  = `SWL_T_SAMPLE_US * `SWL_CLK_MHZ,
  parameter int STOPSU_CYC  = `SWL_T_STOPSU_US * `SWL_CLK_MHZ,
  parameter int BIT_CYC     = `SWL_T_BIT_US * `SWL_CLK_MHZ
) (
  input  wire logic       CLK_I,
  input  wire logic       RST_B_I,
  input  wire logic       DQ_I,
  output var  logic       DQ_O,
  output var  logic       DQ_OE_O,
  input  wire logic [7:0] GAUGE_DATA_I,
  output var  logic [6:0] REG_INDEX_O,
  output var  logic [7:0] NAC_HIGH_O,
  output var  logic [7:0] BATTERY_ID_O,
  output var  logic [7:0] LAST_DISCHARGE_O,
  output var  logic [7:0] MAG_FILTER_O,
  output var  logic [7:0] EDV_THRESHOLD_O,
  output var  logic       GAUGE_RESET_O
);
  localparam logic [`SWL_CNT_W-1:0] BREAK_C   = `SWL_CNT_W'(BREAK_CYC);
  localparam logic [`SWL_CNT_W-1:0] RECOVER_C = `SWL_CNT_W'(RECOVER_CYC - 1);
  localparam logic [`SWL_CNT_W-1:0] START_C   = `SWL_CNT_W'(START_CYC);
  localparam logic [`SWL_CNT_W-1:0] SAMPLE_C  = `SWL_CNT_W'(SAMPLE_CYC - 1);
  localparam logic [`SWL_CNT_W-1:0] STOPSU_C  = `SWL_CNT_W'(STOPSU_CYC);
  localparam logic [`SWL_CNT_W-1:0] BIT_C     = `SWL_CNT_W'(BIT_CYC - 1);

  swl_port_type st;
  swl_port_type next_st;
  logic         fall;
  logic         rise;
  logic         sampled;
  logic [7:0]   rx_byte;
  logic [7:0]   rd_data;

  // Open-drain drive: low while the bit frame needs it
  function automatic logic drive_low(input logic [`SWL_CNT_W-1:0] c, input logic b);
    drive_low = (c < START_C) || (!b && c < STOPSU_C); // R6 R7 R8
  endfunction

  assign fall    = st.line_d && !st.sync2;
  assign rise    = !st.line_d && st.sync2;
  assign sampled = st.in_frame && st.cnt == SAMPLE_C;
  assign rx_byte = {st.sync2, st.shift[7:1]}; // R4

  always_comb begin
    next_st = st;
    next_st.sync1  = DQ_I;
    next_st.sync2  = st.sync1;
    next_st.line_d = st.sync2;
    next_st.wr_en  = 1'b0;
    // Own drive must not look like a line reset
    if (st.sync2 || st.dq_oe) begin
      next_st.low_cnt = '0;
    end else if (st.low_cnt < BREAK_C) begin
      next_st.low_cnt = st.low_cnt + 1'b1;
    end
    unique case (st.state)
      SWL_IDLE: ;
      SWL_RECOVER: begin
        next_st.cnt = st.cnt + 1'b1;
        if (st.cnt == RECOVER_C) begin
          next_st.state = SWL_RX_CMD; // R5
          next_st.cnt = '0;
        end
      end
      SWL_RX_CMD, SWL_RX_DATA: begin
        if (fall && !st.in_frame) begin
          next_st.in_frame = 1'b1;
          next_st.cnt = '0;
        end else if (sampled) begin
          next_st.in_frame = 1'b0;
          next_st.shift = rx_byte;
          next_st.bit_idx = st.bit_idx + 1'b1;
          if (st.bit_idx == `SWL_LAST_BIT) begin // R3
            next_st.cnt = '0;
            if (st.state == SWL_RX_DATA) begin
              next_st.wr_en = 1'b1; // R2
              next_st.state = SWL_RX_CMD;
            end else begin
              next_st.cmd = rx_byte; // R9 R11
              // Write direction waits for data, read turns the line round
              next_st.state = rx_byte[`SWL_CMD_WR_BIT] ? SWL_RX_DATA : SWL_TURN; // R10
            end
          end
        end else if (st.in_frame) begin
          next_st.cnt = st.cnt + 1'b1;
        end
      end
      SWL_TURN: begin
        // Full bit time lets the host finish its stop section first
        next_st.cnt = st.cnt + 1'b1;
        if (st.cnt == BIT_C) begin
          next_st.state = SWL_TX;
          next_st.cnt = '0;
          next_st.shift = rd_data; // R2
          next_st.bit_idx = '0;
        end
      end
      SWL_TX: begin
        next_st.cnt = st.cnt + 1'b1;
        if (st.cnt == BIT_C) begin // R3
          next_st.cnt = '0;
          next_st.shift = {1'b0, st.shift[7:1]}; // R4
          next_st.bit_idx = st.bit_idx + 1'b1;
          if (st.bit_idx == `SWL_LAST_BIT) begin
            next_st.state = SWL_RX_CMD; // R13
          end
        end
      end
    endcase
    next_st.dq_oe = (next_st.state == SWL_TX) && drive_low(next_st.cnt, next_st.shift[0]);
    // A held low beyond the reset time restarts the link from any state
    if (rise && st.low_cnt >= BREAK_C) begin
      next_st.state = SWL_RECOVER; // R5
      next_st.cnt = '0;
      next_st.in_frame = 1'b0;
      next_st.bit_idx = '0;
      next_st.dq_oe = 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      st <= '{sync1: 1'b1, sync2: 1'b1, line_d: 1'b1, state: SWL_IDLE, cnt: '0,
              low_cnt: '0, in_frame: 1'b0, bit_idx: '0, shift: '0, cmd: '0,
              wr_en: 1'b0, dq_oe: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  swl_regfile u_regs (
    .clk_i        (CLK_I),
    .rst_b_i      (RST_B_I),
    .wr_en_i      (st.wr_en),
    .addr_i       (st.cmd[6:0]),
    .wr_data_i    (st.shift),
    .gauge_data_i (GAUGE_DATA_I),
    .nac_high_o   (NAC_HIGH_O),
    .batt_id_o    (BATTERY_ID_O),
    .last_dis_o   (LAST_DISCHARGE_O),
    .mag_filter_o (MAG_FILTER_O),
    .threshold_o  (EDV_THRESHOLD_O),
    .reset_req_o  (GAUGE_RESET_O),
    .rd_data_o    (rd_data)
  );

  // Line is only ever pulled low; the pull-up belongs to the host
  assign DQ_O        = 1'b0; // R1
  assign DQ_OE_O     = st.dq_oe;
  assign REG_INDEX_O = st.cmd[6:0]; // R11

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);

  sequence s_cmd_done;
    st.state == SWL_RX_CMD && sampled && st.bit_idx == `SWL_LAST_BIT;
  endsequence

  sequence s_tx_last;
    st.state == SWL_TX && st.cnt == BIT_C && st.bit_idx == `SWL_LAST_BIT;
  endsequence

  a_break_ready: assert property ( // R5
    (rise && st.low_cnt >= BREAK_C) |=> st.state == SWL_RECOVER && !st.dq_oe)
    else $error("line reset not recognised");
  a_start_low: assert property ( // R6
    (st.state == SWL_TX && st.cnt < START_C) |-> st.dq_oe)
    else $error("start section not driven low");
  a_data_valid: assert property ( // R7
    (st.state == SWL_TX && st.cnt >= START_C && st.cnt < STOPSU_C) |-> st.dq_oe == !st.shift[0])
    else $error("data section does not carry the bit");
  a_stop_high: assert property ( // R8
    (st.state == SWL_TX && st.cnt >= STOPSU_C) |-> !st.dq_oe)
    else $error("line not released for stop");
  a_lsb_first: assert property ( // R4
    (st.state == SWL_TX && st.cnt == BIT_C) |=> st.shift == {1'b0, $past(st.shift[7:1])})
    else $error("transmit order is not lsb first");
  a_cmd_load: assert property ( // R9
    $changed(st.cmd) |-> $past(st.state == SWL_RX_CMD && sampled && st.bit_idx == `SWL_LAST_BIT))
    else $error("command loaded before eight bits");
  a_dir_select: assert property ( // R10
    s_cmd_done |=> st.state == (st.cmd[`SWL_CMD_WR_BIT] ? SWL_RX_DATA : SWL_TURN))
    else $error("command direction not honoured");
  a_done_release: assert property ( // R13
    s_tx_last and !(rise && st.low_cnt >= BREAK_C) |=> st.state == SWL_RX_CMD && !st.dq_oe)
    else $error("line not released after response");
  a_write_pulse: assert property ( // R2
    st.wr_en |-> $past(st.state == SWL_RX_DATA) ##1 !st.wr_en)
    else $error("write strobe outside data phase");
endmodule // swl_port
`default_nettype wire

// ==== tb/swl_host.sv ====
// Host model of the single-wire link, pulling the open-drain line low
`timescale 1ns/100ps
`default_nettype none
`include "swl_cfg.svh"
module swl_host #(
  parameter int START   = 20,
  parameter int STOPSU  = 80,
  parameter int BIT     = 200,
  parameter int BREAK   = 400,
  parameter int RECOVER = `SWL_T_RECOVER_US * `SWL_CLK_MHZ
) (
  input  wire logic clk_i,
  input  wire logic dq_i,
  output var  logic pull_o
);
  initial pull_o = 1'b0;

  // Caller sits just after a rising edge
  task automatic hold(input logic low, input int n);
    pull_o <= low;
    repeat (n) @(posedge clk_i);
  endtask

  // Bench supplies the pull-up, so releasing reads high
  task automatic line_reset();
    hold(1'b1, BREAK + 20);
    // Release outlasts the port's recovery wait before the first frame
    hold(1'b0, BREAK + RECOVER);
  endtask

  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      hold(1'b1, START);
      hold(!b[i], STOPSU - START);
      hold(1'b0, BIT - STOPSU);
    end
  endtask

  // Samples mid data section; a missing frame gives unknown bits
  task automatic recv_byte(output logic [7:0] b);
    int n;
    for (int i = 0; i < 8; i++) begin
      n = 0;
      while (dq_i !== 1'b0 && n < 3 * BIT) begin
        @(posedge clk_i);
        n++;
      end
      repeat ((START + STOPSU) / 2) @(posedge clk_i);
      b[i] = (n < 3 * BIT) ? dq_i : 1'bx;
      repeat (STOPSU) @(posedge clk_i);
    end
  endtask
endmodule // swl_host
`default_nettype wire

// ==== tb/swl_port_test.sv ====
// Self-checking bench of the single-wire serial port
`timescale 1ns/100ps
`default_nettype none
`include "swl_cfg.svh"
module swl_port_test;
  logic       clk_i = 1'b0;
  logic       rst_b_i = 1'b0;
  logic       host_pull;
  logic       dq_oe;
  logic       dq_o;
  logic [7:0] gauge_data = 8'h00;
  logic [6:0] reg_index;
  logic [7:0] nac, bid, lmd, dmf, vts, got;
  logic       grst;
  wire        line = !(dq_oe | host_pull);
  int         n_errors = 0;
  int         checks = 0;
  int         cycles = 0;
  int         pulses = 0;
  logic [6:0] addrs [5] = '{7'h03, 7'h04, 7'h05, 7'h0A, 7'h0C};
  logic [7:0] vals [5] = '{8'h01, 8'h35, 8'hE2, 8'h4B, 8'h17};

  initial forever #2 clk_i = !clk_i;

  // Recovery keeps its full default; the host waits it out after each line reset
  swl_port #(.BREAK_CYC(400), .START_CYC(20), .SAMPLE_CYC(40),
             .STOPSU_CYC(80), .BIT_CYC(200)) i_swl_port (
    .CLK_I(clk_i), .RST_B_I(rst_b_i), .DQ_I(line), .DQ_O(dq_o), .DQ_OE_O(dq_oe),
    .GAUGE_DATA_I(gauge_data), .REG_INDEX_O(reg_index), .NAC_HIGH_O(nac),
    .BATTERY_ID_O(bid), .LAST_DISCHARGE_O(lmd), .MAG_FILTER_O(dmf),
    .EDV_THRESHOLD_O(vts), .GAUGE_RESET_O(grst));

  swl_host i_swl_host (
    .clk_i(clk_i), .dq_i(line), .pull_o(host_pull));

  // Read-only data tagged by index so a wrong index shows
  always @(posedge clk_i) begin
    gauge_data <= {1'b1, reg_index};
    cycles++;
    if (grst === 1'b1)
      pulses++;
    if (cycles == 90000) begin
      n_errors++;
      conclude();
    end
  end

  task automatic conclude();
    if (n_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [39:0] seen, input logic [39:0] want);
    checks++;
    if (seen !== want) begin
      n_errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_swl_host.send_byte({1'b1, a});
    i_swl_host.send_byte(d);
    repeat (4) @(posedge clk_i);
  endtask

  // Waits out the answer's last frame before the next command
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    i_swl_host.send_byte({1'b0, a});
    i_swl_host.recv_byte(d);
    repeat (200) @(posedge clk_i);
    check(dq_oe, 1'b0);
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    check({nac, bid, lmd, dmf, vts}, {24'h0, `SWL_DMF_RST, `SWL_ZERO_RST});
    check(dq_o, 1'b0);
    wr(`SWL_ADDR_NACH, 8'h5A);
    check(nac, `SWL_ZERO_RST);
    i_swl_host.line_reset();
    foreach (addrs[k]) begin
      wr(addrs[k], vals[k]);
      check(reg_index, addrs[k]);
    end
    check({nac, bid, lmd, dmf, vts}, {vals[0], vals[1], vals[2], vals[3], vals[4]});
    wr(7'h06, 8'hFF);
    wr(7'h7F, 8'hFF);
    wr(7'h00, 8'hFF);
    check({nac, bid, lmd, dmf, vts}, {vals[0], vals[1], vals[2], vals[3], vals[4]});
    rd(7'h03, got);
    check(got, vals[0]);
    rd(7'h05, got);
    check(got, vals[2]);
    rd(7'h01, got);
    check(got, 8'h81);
    rd(`SWL_ADDR_RST, got);
    check(got, 8'h00);
    wr(`SWL_ADDR_RST, 8'h7F);
    check(pulses, 0);
    i_swl_host.line_reset();
    wr(`SWL_ADDR_RST, 8'h80);
    check(pulses, 1);
    conclude();
  end
endmodule // swl_port_test
`default_nettype wire
